/* shared/tmr8_pkg.sv */
package tmr8_pkg;
  localparam logic [7:0] TMR8_ADDR_CTRL = 8'h44;
  localparam logic [7:0] TMR8_ADDR_CMP = 8'h47;
  localparam logic [7:0] TMR8_ADDR_MASK = 8'h6e;
  localparam logic [7:0] TMR8_ADDR_CNT = 8'h46;
  localparam logic [7:0] TMR8_ADDR_FLAGS = 8'h35;
  localparam int TMR8_FOC_BIT = 7;
  localparam int TMR8_WM_LOW_BIT = 6;
  localparam int TMR8_WM_HIGH_BIT = 3;
  localparam int TMR8_ACT_HI_BIT = 5;
  localparam int TMR8_ACT_LO_BIT = 4;
  localparam int TMR8_CMP_FLAG_BIT = 1;
  localparam int TMR8_WRAP_FLAG_BIT = 0;
  localparam logic [7:0] TMR8_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR8_CMP_RST = 8'h00;
  localparam logic [1:0] TMR8_MASK_RST = 2'h0;
  localparam logic [7:0] TMR8_CNT_RST = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hff;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [9:0] TMR8_DIV8 = 10'h007;
  localparam logic [9:0] TMR8_DIV64 = 10'h03f;
  localparam logic [9:0] TMR8_DIV256 = 10'h0ff;
  localparam logic [9:0] TMR8_DIV1024 = 10'h3ff;
  localparam logic [1:0] TMR8_MODE_NORMAL = 2'h0;
  localparam logic [1:0] TMR8_MODE_PHASE = 2'h1;
  localparam logic [1:0] TMR8_MODE_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_MODE_FAST = 2'h3;
endpackage

/* src/tmr8_core.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ns
module tmr8_core
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // interrupt handshake
  input wire logic global_irq_enable_i,
  input wire logic cmp_vector_taken_i,
  input wire logic wrap_vector_taken_i,
  output logic cmp_irq_o,
  output logic wrap_irq_o,
  // pins
  input wire logic ext_count_pin_i,
  input wire logic pin_direction_bit_i,
  input wire logic port_data_i,
  output logic wave_output_pin_o,
  output logic wave_output_pin_oe_o
);
  import tmr8_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmp;
    logic [7:0] cmp_buf;
    logic [1:0] mask;
    logic [7:0] cnt;
    logic cmp_flag;
    logic wrap_flag;
    logic wave;
    logic down;
    logic block;
    logic [9:0] presc;
    logic [2:0] ext_sync;
    logic ext_prev;
    logic [7:0] rdata;
  } tmr8_state_t;

  tmr8_state_t s_q;
  tmr8_state_t s_d;

  function automatic logic [1:0] tmr8_mode(input logic [7:0] c);
    tmr8_mode = {c[TMR8_WM_HIGH_BIT], c[TMR8_WM_LOW_BIT]};
  endfunction

  // non-pwm compare action: toggle, clear or set
  function automatic logic tmr8_act(input logic [1:0] a, input logic w);
    tmr8_act = (a == 2'h1) ? ~w : a[0];
  endfunction

  logic [1:0] mode;
  logic [1:0] act;
  logic pwm;
  logic tick;
  logic ext_lvl;
  logic ext_rise;
  logic ext_fall;
  logic match;
  logic [7:0] top;
  logic at_top;
  logic wr_cnt;

  always_comb
  begin
    mode = tmr8_mode(s_q.ctrl);
    act = s_q.ctrl[TMR8_ACT_HI_BIT:TMR8_ACT_LO_BIT];
    pwm = s_q.ctrl[TMR8_WM_LOW_BIT];
    // glitch filter: level changes only when stages two and three agree
    ext_lvl = s_q.ext_prev;
    if (s_q.ext_sync[1] == s_q.ext_sync[2])
    begin
      ext_lvl = s_q.ext_sync[2];
    end
    ext_rise = ext_lvl & ~s_q.ext_prev;
    ext_fall = ~ext_lvl & s_q.ext_prev;
    // pin edges count regardless of pin direction
    case (s_q.ctrl[2:0])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (s_q.presc & TMR8_DIV8) == TMR8_DIV8;
      3'h3: tick = (s_q.presc & TMR8_DIV64) == TMR8_DIV64;
      3'h4: tick = (s_q.presc & TMR8_DIV256) == TMR8_DIV256;
      3'h5: tick = s_q.presc == TMR8_DIV1024;
      3'h6: tick = ext_fall;
      default: tick = ext_rise;
    endcase
    top = (mode == TMR8_MODE_CLEAR) ? s_q.cmp : TMR8_MAX;
    match = (s_q.cnt == s_q.cmp) && !s_q.block;
    at_top = s_q.cnt == top;
    wr_cnt = reg_wr_i && reg_addr_i == TMR8_ADDR_CNT;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_count_pin_i};
    s_d.ext_prev = ext_lvl;
    s_d.presc = s_q.presc + 10'h001;
    s_d.rdata = 8'h00;
    // clears come first so that a same-cycle set from a tick wins
    if (cmp_vector_taken_i || (reg_wr_i && reg_addr_i == TMR8_ADDR_FLAGS
        && reg_wdata_i[TMR8_CMP_FLAG_BIT]))
    begin
      s_d.cmp_flag = 1'b0;
    end
    if (wrap_vector_taken_i || (reg_wr_i && reg_addr_i == TMR8_ADDR_FLAGS
        && reg_wdata_i[TMR8_WRAP_FLAG_BIT]))
    begin
      s_d.wrap_flag = 1'b0;
    end
    if (tick)
    begin
      s_d.block = 1'b0;
      if (match && !(pwm && s_q.cmp == TMR8_MAX && act[1]))
      begin
        s_d.cmp_flag = 1'b1;
      end
      case (mode)
        TMR8_MODE_NORMAL:
        begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == TMR8_MAX)
          begin
            s_d.wrap_flag = 1'b1;
          end
          if (match)
          begin
            s_d.wave = tmr8_act(act, s_q.wave);
          end
        end
        TMR8_MODE_CLEAR:
        begin
          s_d.cnt = (match || at_top) ? TMR8_BOTTOM : s_q.cnt + 8'h01;
          if (s_q.cnt == TMR8_MAX)
          begin
            s_d.wrap_flag = 1'b1;
          end
          if (match)
          begin
            s_d.wave = tmr8_act(act, s_q.wave);
          end
        end
        TMR8_MODE_FAST:
        begin
          s_d.cnt = s_q.cnt + 8'h01; // wraps max to zero
          if (s_q.cnt == TMR8_MAX)
          begin
            s_d.wrap_flag = 1'b1;
            if (act[1])
            begin
              // cmp at top: match skipped, action taken at top
              s_d.wave = (s_q.cmp == TMR8_MAX) ? act[0] : ~act[0];
            end
          end
          else if (match && act[1])
          begin
            s_d.wave = act[0];
          end
        end
        default:
        begin
          if (s_q.cnt == TMR8_MAX)
          begin
            s_d.down = 1'b1;
            s_d.cnt = s_q.cnt - 8'h01;
            if (act[1] && s_q.cmp == TMR8_MAX)
            begin
              s_d.wave = ~act[0];
            end
          end
          else if (s_q.down && s_q.cnt == TMR8_BOTTOM)
          begin
            s_d.down = 1'b0;
            s_d.cnt = s_q.cnt + 8'h01;
            s_d.wrap_flag = 1'b1;
          end
          else
          begin
            s_d.cnt = s_q.down ? s_q.cnt - 8'h01 : s_q.cnt + 8'h01;
          end
          if (match && act[1] && s_q.cmp != TMR8_MAX)
          begin
            s_d.wave = s_q.down ? ~act[0] : act[0];
          end
        end
      endcase
    end
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (reg_wr_i)
    begin
      if (reg_addr_i == TMR8_ADDR_CTRL)
      begin
        s_d.ctrl = {1'b0, reg_wdata_i[6:0]};
        // forced compare: wave only, no flag, no clear
        if (reg_wdata_i[TMR8_FOC_BIT] && !reg_wdata_i[TMR8_WM_LOW_BIT])
        begin
          if (reg_wdata_i[5:4] == 2'h1)
          begin
            s_d.wave = ~s_q.wave;
          end
          else if (reg_wdata_i[5])
          begin
            s_d.wave = reg_wdata_i[4];
          end
        end
        if (!reg_wdata_i[TMR8_WM_LOW_BIT])
        begin
          s_d.down = 1'b0;
        end
      end
      else if (reg_addr_i == TMR8_ADDR_CMP)
      begin
        s_d.cmp_buf = reg_wdata_i;
      end
      else if (reg_addr_i == TMR8_ADDR_MASK)
      begin
        s_d.mask = reg_wdata_i[1:0];
      end
      else if (wr_cnt)
      begin
        s_d.cnt = reg_wdata_i;
        s_d.block = 1'b1;
      end
    end
    // immediate compare update in non-pwm modes
    s_d.cmp = pwm ? s_q.cmp : s_d.cmp_buf;
    // pwm: buffered value loads on the tick at top (count at max), in both pwm modes; a write in that
    // same cycle stays in the buffer for the next turn
    if (pwm && (tick && s_q.cnt == TMR8_MAX))
    begin
      s_d.cmp = s_q.cmp_buf;
    end
    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    if (reg_rd_i)
    begin
      if (reg_addr_i == TMR8_ADDR_CTRL)
      begin
        s_d.rdata = {1'b0, s_q.ctrl[6:0]};
      end
      else if (reg_addr_i == TMR8_ADDR_CMP)
      begin
        s_d.rdata = s_q.cmp_buf;
      end
      else if (reg_addr_i == TMR8_ADDR_MASK)
      begin
        s_d.rdata = {6'h00, s_q.mask};
      end
      else if (reg_addr_i == TMR8_ADDR_CNT)
      begin
        s_d.rdata = s_q.cnt;
      end
      else if (reg_addr_i == TMR8_ADDR_FLAGS)
      begin
        s_d.rdata = {6'h00, s_q.cmp_flag, s_q.wrap_flag};
      end
      else
      begin
        s_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '0;
      s_q.ctrl <= TMR8_CTRL_RST;
      s_q.cmp <= TMR8_CMP_RST;
      s_q.cmp_buf <= TMR8_CMP_RST;
      s_q.mask <= TMR8_MASK_RST;
      s_q.cnt <= TMR8_CNT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = s_q.rdata;
  assign cmp_irq_o = s_q.mask[1] & global_irq_enable_i & s_q.cmp_flag;
  assign wrap_irq_o = s_q.mask[0] & global_irq_enable_i & s_q.wrap_flag;
  // pin taken over when action nonzero
  assign wave_output_pin_o = (act != 2'h0) ? s_q.wave : port_data_i;
  assign wave_output_pin_oe_o = pin_direction_bit_i;
endmodule

/* tb/tmr8_core_monitor.sv */
`timescale 1ns/1ns
module tmr8_core_monitor
  import tmr8_pkg::*;
(
  // clock, reset and register port
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // interrupts and pins
  input wire logic global_irq_enable_i,
  input wire logic cmp_vector_taken_i,
  input wire logic cmp_irq_o,
  input wire logic pin_direction_bit_i,
  input wire logic port_data_i,
  input wire logic wave_output_pin_o,
  input wire logic wave_output_pin_oe_o
);
  // ----------------------------------------
  // shadow of the control register
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic wc;
  logic idle;
  assign wc = reg_wr_i && reg_addr_i == TMR8_ADDR_CTRL;
  // stopped clock: no tick can set or move anything behind our back
  assign idle = ctrl_q[2:0] == 3'h0 && reg_wdata_i[2:0] == 3'h0;
  always_ff @(posedge core_clk_i)
    if (!rstn_i)
      ctrl_q <= 8'h00;
    else if (wc)
      ctrl_q <= reg_wdata_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_pin_enable: assert property (
    wave_output_pin_oe_o == pin_direction_bit_i) else $error("bad oe");
  chk_port_mux: assert property (
    ctrl_q[5:4] == 2'h0 |-> wave_output_pin_o == port_data_i)
    else $error("pin not given back to port");
  chk_cmp_gate: assert property (
    cmp_irq_o |-> global_irq_enable_i) else $error("irq ungated");
  chk_force_reads_zero: assert property (
    reg_rd_i && reg_addr_i == TMR8_ADDR_CTRL |=> !reg_rdata_o[7])
    else $error("force bit read as one");
  chk_mask_high_zero: assert property (
    reg_rd_i && reg_addr_i == TMR8_ADDR_MASK |=> reg_rdata_o[7:2] == 6'h00)
    else $error("mask high bits not zero");
  chk_vector_clears: assert property (
    cmp_vector_taken_i && ctrl_q[2:0] == 3'h0 |=> !cmp_irq_o)
    else $error("vector left compare flag");
  chk_pwm_no_force: assert property (
    wc && idle && reg_wdata_i[7] && reg_wdata_i[6] && ctrl_q[6]
    && ctrl_q[5:4] != 2'h0 && reg_wdata_i[5:4] != 2'h0
    |=> $stable(wave_output_pin_o)) else $error("force acted in pwm");
  chk_force_level: assert property (
    wc && reg_wdata_i[7:6] == 2'h2 && reg_wdata_i[5]
    |=> wave_output_pin_o == $past(reg_wdata_i[4]))
    else $error("forced level wrong");
  chk_force_toggle: assert property (
    wc && idle && reg_wdata_i[7:4] == 4'h9 && ctrl_q[6:4] == 3'h1
    |=> wave_output_pin_o != $past(wave_output_pin_o))
    else $error("forced toggle missing");
endmodule
bind tmr8_core tmr8_core_monitor i_mon (.core_clk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .global_irq_enable_i,
  .cmp_vector_taken_i, .cmp_irq_o, .pin_direction_bit_i, .port_data_i,
  .wave_output_pin_o, .wave_output_pin_oe_o);

/* tb/tmr8_core_tb.sv */
`timescale 1ns/1ns
module tmr8_core_tb;
  import tmr8_pkg::*;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, r;
  logic global_irq_enable_i = 1'b0, cmp_vector_taken_i = 1'b0;
  logic wrap_vector_taken_i = 1'b0, cmp_irq_o, wrap_irq_o, rd_q = 1'b0;
  logic ext_count_pin_i = 1'b0, pin_direction_bit_i = 1'b1;
  logic port_data_i = 1'b0, wave_output_pin_o, wave_output_pin_oe_o;
  logic [15:0] notes[$];
  logic [15:0] nt;
  logic [7:0] fv[6] = '{8'ha0, 8'hb0, 8'h98, 8'h90, 8'he0, 8'he0};
  logic fe[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  int miscompares = 0, n_checks = 0, seed = 32'h0ac8;
  tmr8_core i_dut (.core_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .global_irq_enable_i,
    .cmp_vector_taken_i, .wrap_vector_taken_i, .cmp_irq_o, .wrap_irq_o,
    .ext_count_pin_i, .pin_direction_bit_i, .port_data_i,
    .wave_output_pin_o, .wave_output_pin_oe_o);
  // ----------------------------------------
  // clock, bus tasks and result checking
  // ----------------------------------------
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wave(input logic e);
    @(negedge core_clk_i);
    chk({7'h00, wave_output_pin_o}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // the mask lets a count with one cycle of prescaler phase slack compare
  task automatic rd(input logic [7:0] a, e, input logic [7:0] m = 8'hff);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    notes.push_back({m, e});
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic run(input logic [7:0] c, input int n);
    wr(TMR8_ADDR_CTRL, c);
    repeat (n) @(posedge core_clk_i);
    wr(TMR8_ADDR_CTRL, c & 8'hf8);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      ext_count_pin_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      ext_count_pin_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
  endtask
  task automatic close_out();
    if (notes.size() != 0)
      miscompares++;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk_i)
    rd_q <= reg_rd_i;
  always @(negedge core_clk_i)
  begin
    if (rd_q)
    begin
      nt = notes.pop_front();
      chk(reg_rdata_o & nt[15:8], nt[7:0]);
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(TMR8_ADDR_CTRL, 8'h00);
    rd(TMR8_ADDR_MASK, 8'h00);
    r = 8'($random(seed));
    wr(TMR8_ADDR_CMP, r);
    rd(TMR8_ADDR_CMP, r);
    wr(TMR8_ADDR_CNT, ~r);
    wr(TMR8_ADDR_MASK, 8'hff);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    rd(TMR8_ADDR_MASK, 8'h03);
    port_data_i <= r[0];
    wave(r[0]);
    $display("registers done");
    for (int i = 0; i < 6; i++)
    begin
      wr(TMR8_ADDR_CTRL, fv[i]);
      wave(fe[i]);
    end
    rd(TMR8_ADDR_CTRL, 8'h60);
    rd(TMR8_ADDR_FLAGS, 8'h00);
    rd(TMR8_ADDR_CNT, ~r);
    $display("forced compare done");
    wr(TMR8_ADDR_CMP, 8'hf8);
    wr(TMR8_ADDR_CNT, 8'hf0);
    run(8'h01, 20);
    rd(TMR8_ADDR_FLAGS, 8'h03);
    global_irq_enable_i <= 1'b1;
    @(negedge core_clk_i);
    chk({6'h00, cmp_irq_o, wrap_irq_o}, 8'h03);
    @(posedge core_clk_i);
    cmp_vector_taken_i <= 1'b1;
    wrap_vector_taken_i <= 1'b1;
    @(posedge core_clk_i);
    cmp_vector_taken_i <= 1'b0;
    wrap_vector_taken_i <= 1'b0;
    @(negedge core_clk_i);
    chk({6'h00, cmp_irq_o, wrap_irq_o}, 8'h00);
    $display("flags done");
    wr(TMR8_ADDR_CMP, 8'h80);
    wr(TMR8_ADDR_CNT, 8'h70);
    run(8'h69, 30);
    wave(1'b0);
    run(8'h69, 120);
    wave(1'b1);
    rd(TMR8_ADDR_FLAGS, 8'h03);
    wr(TMR8_ADDR_FLAGS, 8'h03);
    rd(TMR8_ADDR_FLAGS, 8'h00);
    wr(TMR8_ADDR_CNT, 8'h70);
    run(8'h61, 30);
    wave(1'b0);
    run(8'h61, 250);
    wave(1'b1);
    rd(TMR8_ADDR_FLAGS, 8'h02);
    $display("pwm done");
    wr(TMR8_ADDR_CNT, 8'h00);
    run(8'h02, 82);
    rd(TMR8_ADDR_CNT, 8'h0a, 8'hfe);
    wr(TMR8_ADDR_CNT, 8'h00);
    wr(TMR8_ADDR_CTRL, 8'h07);
    pulses(5);
    wr(TMR8_ADDR_CTRL, 8'h06);
    pulses(3);
    wr(TMR8_ADDR_CTRL, 8'h00);
    rd(TMR8_ADDR_CNT, 8'h08);
    wr(TMR8_ADDR_CMP, 8'h10);
    wr(TMR8_ADDR_CNT, 8'h00);
    run(8'h09, 38);
    rd(TMR8_ADDR_CNT, 8'h06);
    $display("clock sources done");
    repeat (3) @(posedge core_clk_i);
    close_out();
  end
endmodule
